// file: rtl/sgr_pkg.sv
// Package with register indices, field positions and reset values.
package sgr_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_SMI_STS1 = 6'h08;
    localparam logic [5:0] IDX_SMI_STATUS_SECOND = 6'h09;
    localparam logic [5:0] IDX_SMI_ENABLE_FIRST  = 6'h0A;
    localparam logic [5:0] IDX_SMI_ENABLE_SECOND  = 6'h0B;
    localparam logic [5:0] IDX_GP1      = 6'h0C;
    localparam logic [5:0] IDX_GP2      = 6'h0D;
    localparam logic [5:0] IDX_GP3      = 6'h0E;
    localparam logic [5:0] IDX_IRQ_STS  = 6'h20;
    localparam logic [5:0] IDX_IRQ_MSK  = 6'h21;

    // Reset values.
    localparam logic [7:0] RST_SMI_STS1 = 8'h00;
    localparam logic [7:0] RST_SMI_STATUS_SECOND = 8'h01;
    localparam logic [7:0] RST_SMI_ENABLE_FIRST  = 8'h00;
    localparam logic [7:0] RST_SMI_ENABLE_SECOND  = 8'h00;
    localparam logic [7:0] RST_GP       = 8'h00;

    // Implemented bits of the pin data, first status and both enable registers.
    localparam logic [7:0] MSK_G1  = 8'hCE;
    localparam logic [7:0] MSK_G2  = 8'h0F;
    localparam logic [7:0] MSK_G3  = 8'hFF;
    localparam logic [7:0] MSK_EN2 = 8'hD7;

    // Field positions.
    localparam int STS2_FIXED_BIT = 0;
    localparam int STS2_U2_BIT    = 1;
    localparam int STS2_U1_BIT    = 2;
    localparam int STS2_PIN_LINE_23_BIT  = 4;
    localparam int EN2_SLOT_BIT   = 6;
    localparam int EN2_PIN_BIT    = 7;

    // Interrupt event bits.
    localparam int IRQ_N          = 3;
    localparam int IRQ_EVT_GROUP  = 0;
    localparam int IRQ_EVT_PIN_LINE_23   = 1;
    localparam int IRQ_EVT_G1     = 2;

    typedef enum logic [0:0] {
        SGR_AHB_IDLE = 1'b0,
        SGR_AHB_WAIT = 1'b1
    } sgr_ahb_st_t;

endpackage

// file: rtl/sgr_reg_if.sv
// Interface carrying register accesses from the bus slave to the bank.
`timescale 1ns/1ns
interface sgr_reg_if;
    logic       req;
    logic       we;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport master (output req, output we, output idx, output wdata,
                    input rdata);
    modport slave  (input req, input we, input idx, input wdata,
                    output rdata);
endinterface

// file: rtl/sgr_ahb_slave.sv
// AHB-Lite slave that turns each word transfer into one register access.
`timescale 1ns/1ns
module sgr_ahb_slave
    import sgr_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    sgr_reg_if.master        bus
);

    typedef struct packed {
        sgr_ahb_st_t st;
        logic        we;
        logic [5:0]  idx;
        logic [7:0]  rdata;
    } sgr_ahb_state_t;

    localparam sgr_ahb_state_t RST = '{st: SGR_AHB_IDLE, we: 1'b0,
                                       idx: 6'h00, rdata: 8'h00};

    sgr_ahb_state_t q;
    sgr_ahb_state_t d;

    // Every data phase takes one wait state so read data comes from a flop.
    always_comb begin
        d         = q;
        bus.req   = 1'b0;
        bus.we    = q.we;
        bus.idx   = q.idx;
        bus.wdata = i_hwdata[7:0];
        case (q.st)
            SGR_AHB_IDLE: begin
                if (i_hsel && i_htrans[1] && i_hready) begin
                    d.st  = SGR_AHB_WAIT;
                    d.we  = i_hwrite;
                    d.idx = i_haddr[7:2];
                end
            end
            SGR_AHB_WAIT: begin
                bus.req = 1'b1;
                d.rdata = q.we ? 8'h00 : bus.rdata;
                d.st    = SGR_AHB_IDLE;
            end
            default: begin
                d.st = SGR_AHB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= RST;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_hrdata    = {24'h000000, q.rdata};
    assign o_hreadyout = (q.st == SGR_AHB_IDLE);
    assign o_hresp     = 1'b0;

endmodule

// file: rtl/sgr_irq_ctl.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
`timescale 1ns/1ns
module sgr_irq_ctl
    import sgr_pkg::*;
#(
    parameter int N = IRQ_N
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [N-1:0] i_evt,
    input  wire logic         i_wr_sts,
    input  wire logic         i_wr_msk,
    input  wire logic [N-1:0] i_wdata,
    output logic      [N-1:0] o_sts,
    output logic      [N-1:0] o_msk,
    output logic              o_irq
);

    typedef struct packed {
        logic [N-1:0] sts;
        logic [N-1:0] msk;
        logic         irq;
    } sgr_irq_state_t;

    sgr_irq_state_t q;
    sgr_irq_state_t d;
    logic [N-1:0]   sts_nxt;

    // A new event wins over a clear written in the same cycle.
    for (genvar i = 0; i < N; i++) begin : g_bit
        assign sts_nxt[i] = i_evt[i] | (q.sts[i] & ~(i_wr_sts & i_wdata[i]));
    end

    always_comb begin
        d     = q;
        d.sts = sts_nxt;
        if (i_wr_msk) begin
            d.msk = i_wdata;
        end
        d.irq = |(d.sts & d.msk);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_sts = q.sts;
    assign o_msk = q.msk;
    assign o_irq = q.irq;

endmodule

// file: rtl/sgr_smi_gpio_regs.sv
// Management interrupt and pin data register bank behind an AHB-Lite port.
`timescale 1ns/1ns
module sgr_smi_gpio_regs
    import sgr_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // AHB-Lite slave port.
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Interrupt sources.
    input  wire logic        i_first_serial_irq,
    input  wire logic        i_second_serial_irq,
    input  wire logic [7:0]  i_pin_line_g1_smi_evt,
    input  wire logic        i_pin_line_23_smi_evt,
    // Pin levels and output latches.
    input  wire logic [7:0]  i_pin_in_g1,
    input  wire logic [7:0]  i_pin_in_g2,
    input  wire logic [7:0]  i_pin_in_g3,
    output logic      [7:0]  o_pin_out_g1,
    output logic      [7:0]  o_pin_out_g2,
    output logic      [7:0]  o_pin_out_g3,
    // Management interrupt outputs.
    output logic             o_group_mgmt_irq_n,
    output logic             o_mgmt_irq_out_pin_n,
    output logic             o_serial_irq2_req,
    output logic             o_irq
);

    typedef struct packed {
        logic [7:0] sts1;
        logic       pin_line_23;
        logic       u1;
        logic       u2;
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] gp1;
        logic [7:0] gp2;
        logic [7:0] gp3;
        logic       grp;
        logic       grp_n;
        logic       pin_n;
        logic       slot;
    } sgr_bank_state_t;

    localparam sgr_bank_state_t RST = '{
        sts1:  RST_SMI_STS1,
        pin_line_23:  1'b0,
        u1:    1'b0,
        u2:    1'b0,
        en1:   RST_SMI_ENABLE_FIRST,
        en2:   RST_SMI_ENABLE_SECOND,
        gp1:   RST_GP,
        gp2:   RST_GP,
        gp3:   RST_GP,
        grp:   1'b0,
        grp_n: 1'b1,
        pin_n: 1'b1,
        slot:  1'b0
    };

    sgr_reg_if bus ();

    sgr_bank_state_t q;
    sgr_bank_state_t d;

    logic             wr;
    logic [7:0]       sts2_rd;
    logic [IRQ_N-1:0] irq_evt;
    logic [IRQ_N-1:0] irq_sts;
    logic [IRQ_N-1:0] irq_msk;
    logic             wr_irq_sts;
    logic             wr_irq_msk;

    sgr_ahb_slave u_ahb (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_ce        (i_ce),
        .i_hsel      (i_hsel),
        .i_haddr     (i_haddr),
        .i_htrans    (i_htrans),
        .i_hwrite    (i_hwrite),
        .i_hwdata    (i_hwdata),
        .i_hready    (i_hready),
        .o_hrdata    (o_hrdata),
        .o_hreadyout (o_hreadyout),
        .o_hresp     (o_hresp),
        .bus         (bus.master)
    );

    assign wr         = bus.req & bus.we;
    assign wr_irq_sts = wr && (bus.idx == IDX_IRQ_STS);
    assign wr_irq_msk = wr && (bus.idx == IDX_IRQ_MSK);

    // Fixed bit, live serial bits and the latched line 23 bit.
    always_comb begin
        sts2_rd                 = 8'h00;
        sts2_rd[STS2_FIXED_BIT] = 1'b1;
        sts2_rd[STS2_U2_BIT]    = q.u2;
        sts2_rd[STS2_U1_BIT]    = q.u1;
        sts2_rd[STS2_PIN_LINE_23_BIT]  = q.pin_line_23;
    end

    // Read multiplexer; unmapped indices read zero.
    always_comb begin
        case (bus.idx)
            IDX_SMI_STS1: begin
                bus.rdata = q.sts1;
            end
            IDX_SMI_STATUS_SECOND: begin
                bus.rdata = sts2_rd;
            end
            IDX_SMI_ENABLE_FIRST: begin
                bus.rdata = q.en1;
            end
            IDX_SMI_ENABLE_SECOND: begin
                bus.rdata = q.en2;
            end
            IDX_GP1: begin
                bus.rdata = i_pin_in_g1 & MSK_G1;
            end
            IDX_GP2: begin
                bus.rdata = i_pin_in_g2 & MSK_G2;
            end
            IDX_GP3: begin
                bus.rdata = i_pin_in_g3 & MSK_G3;
            end
            IDX_IRQ_STS: begin
                bus.rdata = {5'h00, irq_sts};
            end
            IDX_IRQ_MSK: begin
                bus.rdata = {5'h00, irq_msk};
            end
            default: begin
                bus.rdata = 8'h00;
            end
        endcase
    end

    // Next state of the bank.
    always_comb begin
        d = q;

        // Serial interrupt levels are only sampled; software cannot clear
        // them, they drop when the serial port removes its request.
        d.u1 = i_first_serial_irq;
        d.u2 = i_second_serial_irq;

        // Group one event bits: an event in the clearing cycle survives.
        d.sts1 = (i_pin_line_g1_smi_evt
                  | (q.sts1 & ~((wr && bus.idx == IDX_SMI_STS1)
                                ? bus.wdata : 8'h00)))
                 & MSK_G1;

        // Line 23 event bit, cleared by a one written to bit 4.
        d.pin_line_23 = i_pin_line_23_smi_evt
                 | (q.pin_line_23 & ~(wr && bus.idx == IDX_SMI_STATUS_SECOND
                               && bus.wdata[STS2_PIN_LINE_23_BIT]));

        if (wr) begin
            case (bus.idx)
                IDX_SMI_ENABLE_FIRST: begin
                    d.en1 = bus.wdata & MSK_G1;
                end
                IDX_SMI_ENABLE_SECOND: begin
                    // Bit 0 is stored as written; it must stay zero.
                    d.en2 = bus.wdata & MSK_EN2;
                end
                IDX_GP1: begin
                    d.gp1 = bus.wdata & MSK_G1;
                end
                IDX_GP2: begin
                    d.gp2 = bus.wdata & MSK_G2;
                end
                IDX_GP3: begin
                    d.gp3 = bus.wdata & MSK_G3;
                end
                default: begin
                    d.gp3 = q.gp3;
                end
            endcase
        end

        // Group signal from currently held status and enables.
        d.grp = (|(q.sts1 & q.en1))
                | (q.u2 & q.en2[STS2_U2_BIT])
                | (q.u1 & q.en2[STS2_U1_BIT])
                | (q.pin_line_23 & q.en2[STS2_PIN_LINE_23_BIT]);
        d.grp_n = ~d.grp;
        d.pin_n = ~(d.grp & q.en2[EN2_PIN_BIT]);
        d.slot  = d.grp & q.en2[EN2_SLOT_BIT];
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            q <= RST;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // Events for the host-side interrupt: group assertion edge, line 23
    // and any group one line event on a bit implemented in MSK_G1.
    always_comb begin
        irq_evt                = '0;
        irq_evt[IRQ_EVT_GROUP] = d.grp & ~q.grp;
        irq_evt[IRQ_EVT_PIN_LINE_23]  = i_pin_line_23_smi_evt;
        irq_evt[IRQ_EVT_G1]    = |(i_pin_line_g1_smi_evt & MSK_G1);
    end

    sgr_irq_ctl #(
        .N (IRQ_N)
    ) u_irq (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_evt      (irq_evt),
        .i_wr_sts   (wr_irq_sts),
        .i_wr_msk   (wr_irq_msk),
        .i_wdata    (bus.wdata[IRQ_N-1:0]),
        .o_sts      (irq_sts),
        .o_msk      (irq_msk),
        .o_irq      (o_irq)
    );

    assign o_pin_out_g1         = q.gp1;
    assign o_pin_out_g2         = q.gp2;
    assign o_pin_out_g3         = q.gp3;
    assign o_group_mgmt_irq_n   = q.grp_n;
    assign o_mgmt_irq_out_pin_n = q.pin_n;
    assign o_serial_irq2_req    = q.slot;

endmodule

// file: sim/sgr_uart_src_model.sv
// Serial port interrupt sources that hold their level until cleared at source.
`timescale 1ns/1ns
module sgr_uart_src_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_set,
    input  wire logic [1:0] i_clr,
    output logic      [1:0] o_irq
);
    // Bit 0 is the first serial port, bit 1 the second.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_irq <= 2'h0;
        end else begin
            o_irq <= (o_irq | i_set) & ~i_clr;
        end
    end
endmodule

// file: sim/sgr_smi_gpio_regs_assertions.sv
// Port checker for the management interrupt register bank.
`timescale 1ns/1ns
module sgr_smi_gpio_regs_checker (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [7:0]  o_pin_out_g1,
    input wire logic [7:0]  o_pin_out_g2,
    input wire logic        o_group_mgmt_irq_n,
    input wire logic        o_mgmt_irq_out_pin_n,
    input wire logic        o_serial_irq2_req
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_taken;
        i_hsel && i_htrans[1] && i_hready && o_hreadyout && i_ce;
    endsequence
    sequence s_one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    a_wait_one_cycle: assert property (s_taken |=> s_one_wait)
        else $error("data phase length wrong");
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("response not okay");
    a_rdata_narrow: assert property (o_hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_hold: assert property (!$stable(o_hrdata) |-> !$past(o_hreadyout))
        else $error("read data changed outside a data phase");
    a_pin_needs_group: assert property (
        !o_mgmt_irq_out_pin_n |-> !o_group_mgmt_irq_n)
        else $error("pin asserted without group signal");
    a_slot_needs_group: assert property (
        o_serial_irq2_req |-> !o_group_mgmt_irq_n)
        else $error("slot request without group signal");
    a_g1_reserved: assert property ((o_pin_out_g1 & 8'h31) == 8'h00)
        else $error("group one reserved output set");
    a_g2_reserved: assert property (o_pin_out_g2[7:4] == 4'h0)
        else $error("group two reserved output set");
endmodule

bind sgr_smi_gpio_regs sgr_smi_gpio_regs_checker i_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_pin_out_g1(o_pin_out_g1), .o_pin_out_g2(o_pin_out_g2),
    .o_group_mgmt_irq_n(o_group_mgmt_irq_n),
    .o_mgmt_irq_out_pin_n(o_mgmt_irq_out_pin_n),
    .o_serial_irq2_req(o_serial_irq2_req));

// file: sim/sgr_smi_gpio_regs_test.sv
// Self-checking bench for the management interrupt register bank.
`timescale 1ns/1ns
module sgr_smi_gpio_regs_test;
    import sgr_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n    = 1'b0;
    logic        i_hsel     = 1'b0;
    logic [31:0] i_haddr    = 32'h0;
    logic [1:0]  i_htrans   = 2'h0;
    logic        i_hwrite   = 1'b0;
    logic [31:0] i_hwdata   = 32'h0;
    logic [1:0]  uart_set   = 2'h0;
    logic [1:0]  uart_clr   = 2'h0;
    logic [7:0]  g1_evt     = 8'h0;
    logic        g23_evt    = 1'b0;
    logic [7:0]  pin_in [3] = '{8'h0, 8'h0, 8'h0};
    logic [7:0]  pin_out [3];
    logic [1:0]  uart_irq;
    logic [31:0] o_hrdata;
    logic        o_hreadyout, o_hresp, grp_n, pin_n, slot, o_irq;
    logic [7:0]  v;
    int          seed, n_fail, check_count;

    always #5 i_core_clk = ~i_core_clk;

    sgr_uart_src_model i_src (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_set(uart_set), .i_clr(uart_clr), .o_irq(uart_irq));

    sgr_smi_gpio_regs i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_first_serial_irq(uart_irq[0]), .i_second_serial_irq(uart_irq[1]),
        .i_pin_line_g1_smi_evt(g1_evt), .i_pin_line_23_smi_evt(g23_evt),
        .i_pin_in_g1(pin_in[0]), .i_pin_in_g2(pin_in[1]),
        .i_pin_in_g3(pin_in[2]), .o_pin_out_g1(pin_out[0]),
        .o_pin_out_g2(pin_out[1]), .o_pin_out_g3(pin_out[2]),
        .o_group_mgmt_irq_n(grp_n), .o_mgmt_irq_out_pin_n(pin_n),
        .o_serial_irq2_req(slot), .o_irq(o_irq));

    function automatic logic [7:0] gmask(input int g);
        return (g == 0) ? MSK_G1 : (g == 1) ? MSK_G2 : MSK_G3;
    endfunction

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    // Waits for hready at a rising edge, with a bound on the wait.
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_hreadyout !== 1'b1 && k < 20);
        if (o_hreadyout !== 1'b1) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        i_hsel   <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr  <= {24'h0, idx, 2'b00};
        i_hwrite <= wr;
        wait_ready();
        i_hsel   <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= {24'h0, wd};
        wait_ready();
        rd = o_hrdata[7:0];
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rdc(input string nm, input logic [5:0] idx,
                       input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h0, x);
        chk(nm, x, e);
    endtask

    initial begin
        seed = 50102;
        tick(2);
        i_rst_n <= 1'b1;
        rdc("sts1", IDX_SMI_STS1, RST_SMI_STS1);
        rdc("sts2", IDX_SMI_STATUS_SECOND, RST_SMI_STATUS_SECOND);
        rdc("en1", IDX_SMI_ENABLE_FIRST, RST_SMI_ENABLE_FIRST);
        rdc("en2", IDX_SMI_ENABLE_SECOND, RST_SMI_ENABLE_SECOND);
        rdc("unmapped", 6'h3F, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr(IDX_SMI_ENABLE_FIRST, v);
            rdc("en1", IDX_SMI_ENABLE_FIRST, v & MSK_G1);
            wr(IDX_SMI_ENABLE_SECOND, v & 8'h2E);
            rdc("en2", IDX_SMI_ENABLE_SECOND, v & 8'h06);
            for (int g = 0; g < 3; g++) begin
                pin_in[g] <= 8'($random(seed));
                wr(IDX_GP1 + 6'(g), v);
                chk("pin out", pin_out[g], v & gmask(g));
                rdc("pin in", IDX_GP1 + 6'(g), pin_in[g] & gmask(g));
            end
        end
        for (int u = 0; u < 2; u++) begin
            wr(IDX_SMI_ENABLE_SECOND, 8'h80 | 8'(4 >> u));
            uart_set <= 2'(1 << u);
            tick(1);
            uart_set <= 2'h0;
            tick(3);
            wr(IDX_SMI_STATUS_SECOND, 8'hFF);
            rdc("sts2 uart", IDX_SMI_STATUS_SECOND, 8'h01 | 8'(4 >> u));
            chk("group", {7'h0, grp_n}, 8'h00);
            chk("pin", {7'h0, pin_n}, 8'h00);
            uart_clr <= 2'(1 << u);
            tick(1);
            uart_clr <= 2'h0;
            tick(3);
            rdc("sts2 idle", IDX_SMI_STATUS_SECOND, 8'h01);
            chk("group", {7'h0, grp_n}, 8'h01);
        end
        wr(IDX_IRQ_MSK, 8'h00);
        wr(IDX_IRQ_STS, 8'h07);
        wr(IDX_SMI_ENABLE_SECOND, 8'h50);
        g23_evt <= 1'b1;
        tick(1);
        g23_evt <= 1'b0;
        tick(2);
        chk("group", {7'h0, grp_n}, 8'h00);
        chk("slot", {7'h0, slot}, 8'h01);
        chk("pin", {7'h0, pin_n}, 8'h01);
        chk("irq masked", {7'h0, o_irq}, 8'h00);
        wr(IDX_IRQ_MSK, 8'h05);
        tick(2);
        chk("irq", {7'h0, o_irq}, 8'h01);
        wr(IDX_SMI_STATUS_SECOND, 8'h0F);
        rdc("sts2 g23", IDX_SMI_STATUS_SECOND, 8'h11);
        wr(IDX_SMI_STATUS_SECOND, 8'h10);
        tick(2);
        rdc("sts2 clr", IDX_SMI_STATUS_SECOND, 8'h01);
        chk("slot", {7'h0, slot}, 8'h00);
        wr(IDX_IRQ_STS, 8'h07);
        tick(2);
        chk("irq clr", {7'h0, o_irq}, 8'h00);
        v = 8'($random(seed)) | 8'h02;
        g1_evt <= v;
        tick(1);
        g1_evt <= 8'h00;
        tick(2);
        rdc("sts1", IDX_SMI_STS1, v & MSK_G1);
        wr(IDX_SMI_ENABLE_FIRST, 8'h02);
        tick(2);
        chk("group g1", {7'h0, grp_n}, 8'h00);
        wr(IDX_SMI_STS1, 8'h02);
        rdc("sts1 w1c", IDX_SMI_STS1, v & 8'hCC);
        tick(2);
        chk("group g1", {7'h0, grp_n}, 8'h01);
        final_report();
    end
endmodule
